// ### src/sdac_ctrl.sv
// sampling delay adaption controller with register port
// Functional notes
// - dynamic enable set means clock and data delays adapt continuously, clear means no adaption.
// - start mode 0 starts adaption once frequency lock is reported.
// - start mode 1 holds adaption off until the equalizer reports adaption complete.
// - upper limit field bits 7:4, reset 8, bounds the highest delay, legal 0 to 14, 7 mid.
// - lower limit field bits 3:0, reset 6, bounds the lowest delay, legal 0 to 14.
// - error select bits 6:4, reset 7, enable error counting during equalization if any is set.
// - selected errors accumulate over half the relock timer period.
// - a count above the threshold asks the equalizer to step to a higher setting.
// - select bit 2 is clock-bit errors, bit 1 control sequence errors, bit 0 parity.
// - with two-step on, selected errors also validate each candidate setting.
// - order bit 3, reset 0: 0 starts at largest clock delay, 1 starts at the midpoint.
// - two-step waits half the period, checks errors the other half, and moves on at once.
//
// Our own choice: the strobed register port.
`default_nettype none
module sdac_ctrl #(
   parameter int RELOCK_CYCLES = sdac_pkg::RELOCK_CYCLES
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic freq_lock_i,
   input wire logic eq_done_i,
   input wire logic eq_active_i,
   input wire logic [2:0] link_err_i,
   input wire logic early_i,
   input wire logic late_i,
   output logic [3:0] delay_setting_o,
   output logic eq_step_up_o,
   output logic cand_reject_o,
   output logic adapting_o
);
   initial begin
      if (RELOCK_CYCLES < 4 || RELOCK_CYCLES % 2 != 0) $error("bad relock period");
   end
   localparam int HALF = RELOCK_CYCLES / 2;

   // clamp a setting into the programmed window
   function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo,
                                        input logic [3:0] hi);
      logic [3:0] r;
      r = v;
      if (r > hi) r = hi;
      if (r < lo) r = lo;
      return r;
   endfunction

   // register state
   logic [7:0] delay_ctl, next_delay_ctl;
   logic [3:0] upper, next_upper, lower, next_lower;
   logic [2:0] err_sel, next_err_sel;
   logic order, next_order, two_step, next_two_step;
   logic [7:0] thresh, next_thresh;
   logic [7:0] rdata, next_rdata;

   // two-flop synchronisers for link status inputs from another domain
   logic [4:0] sync1, sync2;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1 <= '0;
         sync2 <= '0;
      end else begin
         sync1 <= {freq_lock_i, eq_done_i, eq_active_i, early_i, late_i};
         sync2 <= sync1;
      end
   end
   logic lock_s, eq_done_s, eq_active_s, early_s, late_s;
   assign {lock_s, eq_done_s, eq_active_s, early_s, late_s} = sync2;

   logic [2:0] err1, err2;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         err1 <= '0;
         err2 <= '0;
      end else begin
         err1 <= link_err_i;
         err2 <= err1;
      end
   end

   // register writes and read data
   always_comb begin
      next_delay_ctl = delay_ctl;
      next_upper = upper;
      next_lower = lower;
      next_err_sel = err_sel;
      next_order = order;
      next_two_step = two_step;
      next_thresh = thresh;
      next_rdata = 8'h00;
      if (wr_i) begin
         case (addr_i)
            sdac_pkg::ADDR_DELAY_CTL: next_delay_ctl = wdata_i;
            sdac_pkg::ADDR_LIMITS: begin
               next_upper = wdata_i[sdac_pkg::LSB_UPPER +: 4];
               next_lower = wdata_i[3:0];
            end
            sdac_pkg::ADDR_EQ_CTL: begin
               next_err_sel = wdata_i[sdac_pkg::LSB_ERR_SEL +: 3];
               next_order = wdata_i[sdac_pkg::BIT_ORDER];
               next_two_step = wdata_i[sdac_pkg::BIT_TWO_STEP];
            end
            sdac_pkg::ADDR_ERR_THRESH: next_thresh = wdata_i; // zero is caller's fault
            default: ;
         endcase
      end
      if (rd_i) begin
         case (addr_i)
            sdac_pkg::ADDR_DELAY_CTL: next_rdata = delay_ctl;
            sdac_pkg::ADDR_LIMITS: next_rdata = {upper, lower};
            sdac_pkg::ADDR_EQ_CTL: next_rdata = {1'b0, err_sel, order, two_step, 2'b00};
            sdac_pkg::ADDR_ERR_THRESH: next_rdata = thresh;
            sdac_pkg::ADDR_STATUS: next_rdata = {3'b000, adapting_o, delay_setting_o};
            default: next_rdata = 8'h00; // unmapped reads zero
         endcase
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         delay_ctl <= sdac_pkg::RST_DELAY_CTL;
         upper <= sdac_pkg::RST_UPPER;
         lower <= sdac_pkg::RST_LOWER;
         err_sel <= sdac_pkg::RST_ERR_SEL;
         order <= sdac_pkg::RST_ORDER;
         two_step <= sdac_pkg::RST_TWO_STEP;
         thresh <= sdac_pkg::RST_ERR_THRESH;
         rdata <= 8'h00;
      end else begin
         delay_ctl <= next_delay_ctl;
         upper <= next_upper;
         lower <= next_lower;
         err_sel <= next_err_sel;
         order <= next_order;
         two_step <= next_two_step;
         thresh <= next_thresh;
         rdata <= next_rdata;
      end
   end
   assign rdata_o = rdata;

   logic dyn_en, start_mode;
   assign dyn_en = delay_ctl[sdac_pkg::BIT_DYN_EN];
   assign start_mode = delay_ctl[sdac_pkg::BIT_START_MODE];

   // adaption gate: lock or equalizer completion, per start mode
   logic start_ok;
   assign start_ok = start_mode ? eq_done_s : lock_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_HOLD = 3'b100
   } sdac_state_t;
   sdac_state_t state, next_state;
   logic [3:0] delay, next_delay;
   logic [3:0] start_point;
   // order 0 starts at the largest clock delay, order 1 at the midpoint
   assign start_point = order ? sdac_pkg::DELAY_MID : sdac_pkg::DELAY_TOP;

   // delay adaption state machine; early/late nudges the setting by one
   always_comb begin
      next_state = state;
      next_delay = clamp(delay, lower, upper);
      case (state)
         ST_IDLE: begin
            if (dyn_en && start_ok) begin
               next_state = ST_RUN;
               next_delay = clamp(start_point, lower, upper);
            end
         end
         ST_RUN: begin
            if (!dyn_en) next_state = ST_IDLE;
            else if (!start_ok) next_state = ST_HOLD;
            else if (early_s && !late_s && delay < upper) next_delay = delay + 4'h1;
            else if (late_s && !early_s && delay > lower) next_delay = delay - 4'h1;
         end
         ST_HOLD: begin
            if (!dyn_en) next_state = ST_IDLE;
            else if (start_ok) next_state = ST_RUN;
         end
         default: next_state = ST_IDLE;
      endcase
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state <= ST_IDLE;
         delay <= sdac_pkg::DELAY_MID;
      end else begin
         state <= next_state;
         delay <= next_delay;
      end
   end
   // output is clamped too so a limit rewrite takes effect at once
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) delay_setting_o <= sdac_pkg::DELAY_MID;
      else delay_setting_o <= clamp(next_delay, next_lower, next_upper);
   end
   assign adapting_o = (state == ST_RUN);

   // error counting during equalization, only if some source is selected
   logic err_run;
   assign err_run = eq_active_s && (|err_sel);
   logic win_end, win_over;
   sdac_err_window #(.HALF_CYCLES(HALF)) u_win (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .run_i(err_run),
      .err_sel_i(err_sel),
      .err_i({err2[sdac_pkg::ERR_CLK_BIT], err2[sdac_pkg::ERR_CTL_SEQ],
              err2[sdac_pkg::ERR_PARITY]}),
      .thresh_i(thresh),
      .window_end_o(win_end),
      .over_o(win_over),
      .count_o()
   );
   // step request pulses one cycle after a window closes over threshold
   logic win_end_d, next_reject;
   logic second_half, next_second_half;
   always_comb begin
      next_second_half = err_run ? (win_end ? ~second_half : second_half) : 1'b0;
      // two-step: the second half's errors reject the candidate immediately
      next_reject = err_run && two_step && second_half && (|(err2 & err_sel));
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         win_end_d <= 1'b0;
         second_half <= 1'b0;
         cand_reject_o <= 1'b0;
      end else begin
         win_end_d <= win_end;
         second_half <= next_second_half;
         cand_reject_o <= next_reject;
      end
   end
   assign eq_step_up_o = win_end_d && win_over;

   a_step_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      eq_step_up_o |-> $past(win_end) && $past(err_run))
      else $error("step request without window end");
   a_delay_upper: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !$changed(upper) && !$changed(lower) && $past(lower) <= $past(upper)
      |-> delay_setting_o <= upper)
      else $error("delay above upper limit");
   a_delay_lower: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !$changed(upper) && !$changed(lower) && $past(lower) <= $past(upper)
      |-> delay_setting_o >= lower)
      else $error("delay below lower limit");
   a_dis_idle: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !dyn_en |=> state == ST_IDLE)
      else $error("adapting while disabled");
   a_mode_lock: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_IDLE && dyn_en && !start_mode && lock_s |=> adapting_o)
      else $error("no start after lock");
   a_mode_eq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_IDLE && start_mode && !eq_done_s |=> !adapting_o)
      else $error("started before equalizer done");
   a_order_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      state == ST_IDLE && next_state == ST_RUN && order && lower <= sdac_pkg::DELAY_MID
      && upper >= sdac_pkg::DELAY_MID |=> delay == sdac_pkg::DELAY_MID)
      else $error("midpoint start missed");
   a_no_sel_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      err_sel == 3'h0 [*2] |-> !eq_step_up_o && !cand_reject_o)
      else $error("counting with no error source");
   a_reject_cause: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      cand_reject_o |-> $past(two_step) && $past(second_half))
      else $error("reject outside second step");
endmodule
`default_nettype wire

// ### common/sdac_pkg.sv
// constants for the sampling delay adaption controller
`default_nettype none
package sdac_pkg;
   // register offsets
   localparam logic [7:0] ADDR_DELAY_CTL = 8'h40;
   localparam logic [7:0] ADDR_LIMITS = 8'h41;
   localparam logic [7:0] ADDR_EQ_CTL = 8'h42;
   localparam logic [7:0] ADDR_ERR_THRESH = 8'h43;
   localparam logic [7:0] ADDR_STATUS = 8'h44;
   // field positions
   localparam int BIT_DYN_EN = 0;
   localparam int BIT_START_MODE = 1;
   localparam int BIT_TWO_STEP = 2;
   localparam int BIT_ORDER = 3;
   localparam int LSB_ERR_SEL = 4;
   localparam int LSB_UPPER = 4;
   localparam int ERR_CLK_BIT = 2;
   localparam int ERR_CTL_SEQ = 1;
   localparam int ERR_PARITY = 0;
   // reset values
   localparam logic [7:0] RST_DELAY_CTL = 8'h00;
   localparam logic [3:0] RST_UPPER = 4'h8;
   localparam logic [3:0] RST_LOWER = 4'h6;
   localparam logic [2:0] RST_ERR_SEL = 3'h7;
   localparam logic RST_ORDER = 1'b0;
   localparam logic RST_TWO_STEP = 1'b1;
   localparam logic [7:0] RST_ERR_THRESH = 8'h01;
   // delay setting landmarks
   localparam logic [3:0] DELAY_MID = 4'h7;
   localparam logic [3:0] DELAY_TOP = 4'he;
   // default relock period in cycles (stand-in, programmable by parameter)
   localparam int RELOCK_CYCLES = 4096;
endpackage
`default_nettype wire

// ### src/sdac_err_window.sv
// error accumulation over a half relock period window
`default_nettype none
module sdac_err_window #(
   parameter int HALF_CYCLES = 2048
) (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic run_i,
   input wire logic [2:0] err_sel_i,
   input wire logic [2:0] err_i,
   input wire logic [7:0] thresh_i,
   output logic window_end_o,
   output logic over_o,
   output logic [7:0] count_o
);
   initial begin
      if (HALF_CYCLES < 2) $error("half period too short");
   end
   logic [31:0] timer, next_timer;
   logic [7:0] count, next_count;
   logic over, next_over;
   logic hit;
   // any selected error source counts one per cycle
   always_comb begin
      hit = |(err_i & err_sel_i);
      next_timer = timer;
      next_count = count;
      next_over = over;
      window_end_o = 1'b0;
      if (!run_i) begin
         next_timer = '0;
         next_count = '0;
         next_over = 1'b0;
      end else if (timer == 32'(HALF_CYCLES - 1)) begin
         window_end_o = 1'b1;
         next_timer = '0;
         next_count = '0;
         next_over = (count > thresh_i);
      end else begin
         next_timer = timer + 32'h1;
         if (hit && count != 8'hff) next_count = count + 8'h1; // saturate
      end
   end
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         timer <= '0;
         count <= '0;
         over <= 1'b0;
      end else begin
         timer <= next_timer;
         count <= next_count;
         over <= next_over;
      end
   end
   assign over_o = over;
   assign count_o = count;
endmodule
`default_nettype wire

// ### tb/sdac_link_model.sv
// far-side link model: lock, equalizer status, error and phase levels
`default_nettype none
module sdac_link_model (
   input wire logic clk_i,
   input wire logic lock_i,
   input wire logic done_i,
   input wire logic active_i,
   input wire logic [2:0] err_i,
   input wire logic [1:0] dir_i,
   output logic freq_lock_o,
   output logic eq_done_o,
   output logic eq_active_o,
   output logic [2:0] link_err_o,
   output logic early_o,
   output logic late_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      freq_lock_o = 1'b0;
      eq_done_o = 1'b0;
      eq_active_o = 1'b0;
      link_err_o = 3'h0;
      early_o = 1'b0;
      late_o = 1'b0;
   end
   // levels change one edge after the command, like a real remote link
   always @(posedge clk_i) begin
      freq_lock_o <= lock_i;
      eq_done_o <= done_i;
      eq_active_o <= active_i;
      link_err_o <= err_i;
      early_o <= dir_i[1];
      late_o <= dir_i[0];
   end
endmodule
`default_nettype wire

// ### tb/sdac_ctrl_test.sv
// self-checking bench for the sampling delay adaption controller
`default_nettype none
module sdac_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [7:0] addr_i = 8'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic lock = 1'b0, done = 1'b0, active = 1'b0;
   logic [2:0] err = 3'h0;
   logic [1:0] dir = 2'h0;
   logic [7:0] rdata_o, d;
   logic freq_lock_i, eq_done_i, eq_active_i, early_i, late_i, s;
   logic [2:0] link_err_i;
   logic [3:0] delay_setting_o;
   logic eq_step_up_o, cand_reject_o, adapting_o;
   int err_total = 0;
   int n_checks = 0;
   always #25 clk_i = ~clk_i;
   sdac_link_model link (.clk_i(clk_i), .lock_i(lock), .done_i(done), .active_i(active),
      .err_i(err), .dir_i(dir), .freq_lock_o(freq_lock_i), .eq_done_o(eq_done_i),
      .eq_active_o(eq_active_i), .link_err_o(link_err_i), .early_o(early_i), .late_o(late_i));
   // short relock period keeps each error window at 8 cycles
   sdac_ctrl #(.RELOCK_CYCLES(16)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .freq_lock_i(freq_lock_i),
      .eq_done_i(eq_done_i), .eq_active_i(eq_active_i), .link_err_i(link_err_i),
      .early_i(early_i), .late_i(late_i), .delay_setting_o(delay_setting_o),
      .eq_step_up_o(eq_step_up_o), .cand_reject_o(cand_reject_o), .adapting_o(adapting_o));
   task automatic report_and_stop();
      if (err_total == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask
   // which: 0 adapting high, 1 step-up pulse, 2 candidate reject, 3 adapting low
   task automatic look(input int which, input int lim, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(posedge clk_i);
         #1;
         case (which)
            0: seen = (adapting_o === 1'b1);
            1: seen = (eq_step_up_o === 1'b1);
            2: seen = (cand_reject_o === 1'b1);
            default: seen = (adapting_o === 1'b0);
         endcase
      end
   endtask
   // bounded wait that must succeed, otherwise the run is closed
   task automatic need(input string name, input int which);
      logic ok;
      look(which, 40, ok);
      check(name, {7'h0, ok}, 8'h01);
      if (ok !== 1'b1) report_and_stop();
   endtask
   task automatic t_reset_values();
      check("delay", {4'h0, delay_setting_o}, 8'h07);
      rd(sdac_pkg::ADDR_DELAY_CTL, d);
      check("ctl", d, 8'h00);
      // read data must fall back to zero one cycle after it stood
      @(posedge clk_i);
      #1 check("rdata drop", rdata_o, 8'h00);
      rd(sdac_pkg::ADDR_LIMITS, d);
      check("limits", d, 8'h86);
      rd(sdac_pkg::ADDR_EQ_CTL, d);
      check("eqctl", d, 8'h74);
      rd(sdac_pkg::ADDR_ERR_THRESH, d);
      check("thresh", d, 8'h01);
      rd(8'h50, d);
      check("unmapped", d, 8'h00);
   endtask
   task automatic t_lock_start();
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h01);
      look(0, 12, s);
      check("early start", {7'h0, s}, 8'h00);
      lock <= 1'b1;
      need("lock start", 0);
      repeat (2) @(posedge clk_i);
      check("start point", {4'h0, delay_setting_o}, 8'h08);
      rd(sdac_pkg::ADDR_STATUS, d);
      check("status", d, 8'h18);
      dir <= 2'h1;
      repeat (20) @(posedge clk_i);
      check("floor", {4'h0, delay_setting_o}, 8'h06);
      dir <= 2'h2;
      repeat (20) @(posedge clk_i);
      check("ceiling", {4'h0, delay_setting_o}, 8'h08);
      dir <= 2'h0;
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h00);
      need("disable", 3);
   endtask
   task automatic t_mid_order();
      // midpoint order only with upper at 7 or more and lower at 7 or less
      wr(sdac_pkg::ADDR_LIMITS, 8'he0);
      wr(sdac_pkg::ADDR_EQ_CTL, 8'h7c);
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h01);
      need("mid start", 0);
      repeat (2) @(posedge clk_i);
      check("mid point", {4'h0, delay_setting_o}, 8'h07);
      dir <= 2'h2;
      repeat (20) @(posedge clk_i);
      check("top", {4'h0, delay_setting_o}, 8'h0e);
      dir <= 2'h0;
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h00);
      need("stop", 3);
   endtask
   task automatic t_eq_start();
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h03);
      look(0, 12, s);
      check("held off", {7'h0, s}, 8'h00);
      done <= 1'b1;
      need("eq start", 0);
      wr(sdac_pkg::ADDR_DELAY_CTL, 8'h00);
      need("idle", 3);
   endtask
   // run errors on pattern e with eq control value v, report whether step-up came
   task automatic err_run(input logic [7:0] v, input logic [2:0] e, output logic seen);
      wr(sdac_pkg::ADDR_EQ_CTL, v);
      err <= e;
      repeat (20) @(posedge clk_i);
      look(1, 40, seen);
   endtask
   task automatic t_errors();
      wr(sdac_pkg::ADDR_ERR_THRESH, 8'h02);
      active <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         err_run(8'h10 << k, 3'h1 << k, s);
         check("step", {7'h0, s}, 8'h01);
         err_run(8'h10 << k, ~(3'h1 << k), s);
         check("other", {7'h0, s}, 8'h00);
      end
      err_run(8'h00, 3'h7, s);
      check("no select", {7'h0, s}, 8'h00);
      err_run(8'h74, 3'h7, s);
      look(2, 40, s);
      check("reject", {7'h0, s}, 8'h01);
      err_run(8'h70, 3'h7, s);
      look(2, 40, s);
      check("no reject", {7'h0, s}, 8'h00);
      err <= 3'h0;
      active <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      t_reset_values();
      t_lock_start();
      t_mid_order();
      t_eq_start();
      t_errors();
      report_and_stop();
   end
endmodule
`default_nettype wire
